// ==== include/rts_pkg.sv ====
// Package: constants and types for the reader trigger sequencer
package rts_pkg;
  // Timebase
  localparam int CLK_HZ   = 50_000_000;
  localparam int TICK_US  = 1000;  // 1 ms timebase
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // Register offsets
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_MCYCLE = 4'h1;
  localparam logic [3:0] A_BURST  = 4'h2;
  localparam logic [3:0] A_DECTO  = 4'h3;
  localparam logic [3:0] A_DUP    = 4'h4;
  localparam logic [3:0] A_GAIN   = 4'h5;
  localparam logic [3:0] A_HYST   = 4'h6;
  localparam logic [3:0] A_FRMN   = 4'h7;
  localparam logic [3:0] A_FGAP   = 4'h8;
  localparam logic [3:0] A_CMD    = 4'h9;
  localparam logic [3:0] A_MISS   = 4'hA;
  localparam logic [3:0] A_STAT   = 4'hB;

  // Limits, ms unless noted
  localparam logic [15:0] MCYCLE_MIN = 16'h0014;  // 20, exclusive
  localparam logic [15:0] ATTEMPT_MS = 16'h0014;  // 20
  localparam logic [15:0] BURST_INF  = 16'h7531;  // 30001
  localparam logic [15:0] DECTO_MIN  = 16'h000A;  // 10
  localparam logic [15:0] DECTO_MAX  = 16'h2710;  // 10000
  localparam logic [15:0] DUP_MAX    = 16'h7530;  // 30000
  localparam logic [15:0] FRMN_MIN   = 16'h0002;
  localparam logic [15:0] FRMN_MAX   = 16'h0009;
  localparam logic [15:0] FGAP_MIN   = 16'h0014;  // 20
  localparam logic [15:0] FGAP_MAX   = 16'h7530;  // 30000
  localparam logic [15:0] CMD_STOP   = 16'h8400;
  localparam logic [7:0]  GAIN_MAX   = 8'hFF;

  // Values after reset
  localparam logic [15:0] RST_MCYCLE = 16'h0064;
  localparam logic [15:0] RST_BURST  = 16'h03E8;
  localparam logic [15:0] RST_DECTO  = 16'h03E8;
  localparam logic [15:0] RST_DUP    = 16'h0000;
  localparam logic [7:0]  RST_GAIN   = 8'h64;
  localparam logic [7:0]  RST_HW     = 8'h05;
  localparam logic [3:0]  RST_HK     = 4'h0;
  localparam logic [3:0]  RST_FRMN   = 4'h4;
  localparam logic [15:0] RST_FGAP   = 16'h0064;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_INTERVAL, MODE_FRAME} rts_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_CAP, ST_DEC, ST_GAP} rts_state_t;

  typedef struct packed {
    rts_mode_t   mode;
    logic        falling;
    logic        level_en;
    logic        async_en;
    logic        sup_bad;
    logic        stop_good;
    logic [15:0] mcycle;
    logic [15:0] burst;
    logic [15:0] dec_to;
    logic [15:0] dup;
    logic [7:0]  gain;
    logic [7:0]  hwidth;
    logic [3:0]  hk;
    logic [3:0]  frame_n;
    logic [15:0] gap;
  } rts_cfg_t;

  typedef struct packed {
    logic        done;
    logic        good;
    logic [15:0] data;
  } rts_dec_t;

  typedef struct packed {
    logic        valid;
    logic        good;
    logic [15:0] data;
  } rts_res_t;

  localparam rts_cfg_t CFG_RST = '{mode: MODE_SINGLE, falling: 1'b0, level_en: 1'b0,
    async_en: 1'b0, sup_bad: 1'b0, stop_good: 1'b0, mcycle: RST_MCYCLE, burst: RST_BURST,
    dec_to: RST_DECTO, dup: RST_DUP, gain: RST_GAIN, hwidth: RST_HW, hk: RST_HK,
    frame_n: RST_FRMN, gap: RST_FGAP};
endpackage

// ==== src/rts_gain_step.sv ====
// Gain of one hysteresis step, clamped and registered
`timescale 1ns/1ns
`default_nettype none
module rts_gain_step
  import rts_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  // Step request
  input  wire logic [7:0] base_in,
  input  wire logic [7:0] width_in,
  input  wire logic [4:0] idx_in,
  // Result
  output logic [7:0]      gain_out
);
  typedef struct packed {
    logic [7:0] gain;
  } rts_gst_t;

  rts_gst_t    gst_ff;
  rts_gst_t    nxt_gst;
  logic [5:0]  idx_p1;
  logic [11:0] prod;
  logic [12:0] up;
  logic [12:0] dn;

  // Odd steps add, even steps subtract, magnitude grows every two
  assign idx_p1 = {1'b0, idx_in} + 6'h01;
  assign prod   = idx_p1[4:1] * width_in;
  assign up     = {5'h00, base_in} + {1'b0, prod};
  assign dn     = {5'h00, base_in} - {1'b0, prod};

  always_comb begin
    nxt_gst = gst_ff;
    if (clk_en_in) begin
      if (idx_in[0]) begin
        nxt_gst.gain = (up > {5'h00, GAIN_MAX}) ? GAIN_MAX : up[7:0];
      end else begin
        nxt_gst.gain = dn[12] ? 8'h00 : dn[7:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gst_ff <= '0;
    end else begin
      gst_ff <= nxt_gst;
    end
  end

  assign gain_out = gst_ff.gain;

  property p_clamp_hi;
    @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && idx_in[0] && up > 13'h00FF) |=> (gain_out == 8'hFF);
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("gain not clamped at top");

  property p_clamp_lo;
    @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && !idx_in[0] && dn[12]) |=> (gain_out == 8'h00);
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("gain not clamped at zero");
endmodule
`default_nettype wire

// ==== src/rts_trigger_seq.sv ====
// Trigger sequencer: trigger conditioning, capture/decode sequencing, registers
`timescale 1ns/1ns
`default_nettype none
module rts_trigger_seq
  import rts_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // Trigger inputs
  input  wire logic        trig_in,
  input  wire logic        trig2_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  // Imager and decoder
  input  wire logic        cap_done_in,
  input  wire rts_dec_t    dec_in,
  output logic             capture_out,
  output logic             abort_out,
  output logic [7:0]       gain_out,
  output rts_res_t         res_out,
  output logic             busy_out
);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  typedef struct packed {
    rts_cfg_t    cfg;
    rts_state_t  state;
    logic        t_s1;
    logic        t_s2;
    logic        t_prv;
    logic        u_s1;
    logic        u_s2;
    logic        u_prv;
    logic [15:0] tick_cnt;
    logic [15:0] ms_trig;
    logic [15:0] ms_burst;
    logic [15:0] ms_dec;
    logic [15:0] ms_gap;
    logic [15:0] ms_dup;
    logic [15:0] budget;
    logic [4:0]  idx;
    logic [3:0]  nimg;
    logic        pend;
    logic        caprdy;
    logic        cap_pulse;
    logic        abort_pulse;
    rts_res_t    res;
    logic [15:0] last_data;
    logic        have_last;
    logic [15:0] missed;
    logic [15:0] rdata;
  } rts_core_t;

  rts_core_t   core_ff;
  rts_core_t   nxt_core;
  logic        tick;
  logic        act;
  logic        edge_det;
  logic        t2_edge;
  logic        lvl_mode;
  logic        spaced;
  logic        cmd_stop;
  logic        unlim;
  logic        stop_req;
  logic [15:0] eff_to;
  logic        to_hit;
  logic        fin;
  logic        good;
  logic        dup;
  logic        hyst_on;
  logic        last_h;
  logic [4:0]  nxt_step;
  logic        bbusy;
  logic        async_go;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  assign tick     = core_ff.tick_cnt == TICK_LAST;
  assign act      = core_ff.t_s2 ^ core_ff.cfg.falling;
  assign edge_det = act & ~(core_ff.t_prv ^ core_ff.cfg.falling);
  assign t2_edge  = core_ff.u_s2 & ~core_ff.u_prv;
  assign lvl_mode = core_ff.cfg.level_en & (core_ff.cfg.mode == MODE_SINGLE);
  assign spaced   = core_ff.ms_trig >= core_ff.cfg.mcycle;
  assign cmd_stop = reg_wr_in & (reg_addr_in == A_CMD) & (reg_wdata_in == CMD_STOP);
  assign unlim    = core_ff.cfg.burst == BURST_INF;
  assign stop_req = (cmd_stop | t2_edge) & unlim & (core_ff.cfg.mode == MODE_INTERVAL)
                  & (core_ff.state != ST_IDLE);
  // Machine cycle also caps the decode time in single mode
  assign eff_to   = (core_ff.cfg.mode == MODE_SINGLE && core_ff.cfg.mcycle < core_ff.cfg.dec_to)
                  ? core_ff.cfg.mcycle : core_ff.cfg.dec_to;
  assign to_hit   = (core_ff.state == ST_DEC) & (core_ff.ms_dec >= eff_to) & ~dec_in.done;
  assign fin      = (core_ff.state == ST_DEC) & (dec_in.done | to_hit);
  assign good     = (core_ff.state == ST_DEC) & dec_in.done & dec_in.good;
  assign dup      = core_ff.have_last & (dec_in.data == core_ff.last_data)
                  & (core_ff.ms_dup < core_ff.cfg.dup);
  assign hyst_on  = core_ff.cfg.hk != 4'h0;
  assign last_h   = core_ff.idx == {core_ff.cfg.hk, 1'b0};
  assign nxt_step = last_h ? 5'h00 : core_ff.idx + 5'h01;
  assign bbusy    = (core_ff.cfg.mode != MODE_SINGLE) & (core_ff.state != ST_IDLE);
  assign async_go = (core_ff.state == ST_DEC) & (core_ff.cfg.mode == MODE_SINGLE)
                  & core_ff.cfg.async_en & edge_det & spaced & ~core_ff.pend & ~fin;

  always_comb begin
    nxt_core = core_ff;
    if (clk_en_in) begin
      nxt_core.cap_pulse   = 1'b0;
      nxt_core.abort_pulse = 1'b0;
      nxt_core.res.valid   = 1'b0;
      nxt_core.rdata       = 16'h0000;
      nxt_core.tick_cnt    = tick ? 16'h0000 : core_ff.tick_cnt + 16'h0001;
      nxt_core.t_s1        = trig_in;
      nxt_core.t_s2        = core_ff.t_s1;
      nxt_core.t_prv       = core_ff.t_s2;
      nxt_core.u_s1        = trig2_in;
      nxt_core.u_s2        = core_ff.u_s1;
      nxt_core.u_prv       = core_ff.u_s2;
      if (tick) begin
        nxt_core.ms_trig  = sat_inc(core_ff.ms_trig);
        nxt_core.ms_burst = sat_inc(core_ff.ms_burst);
        nxt_core.ms_dec   = sat_inc(core_ff.ms_dec);
        nxt_core.ms_gap   = sat_inc(core_ff.ms_gap);
        nxt_core.ms_dup   = sat_inc(core_ff.ms_dup);
      end

      // Out-of-range writes leave the setting unchanged
      if (reg_wr_in) begin
        case (reg_addr_in)
          A_CTRL: begin
            if (reg_wdata_in[1:0] != 2'h3) begin
              nxt_core.cfg.mode = rts_mode_t'(reg_wdata_in[1:0]);
            end
            nxt_core.cfg.falling   = reg_wdata_in[2];
            nxt_core.cfg.level_en  = reg_wdata_in[3];
            nxt_core.cfg.async_en  = reg_wdata_in[4];
            nxt_core.cfg.sup_bad   = reg_wdata_in[5];
            nxt_core.cfg.stop_good = reg_wdata_in[6];
          end
          A_MCYCLE: if (reg_wdata_in > MCYCLE_MIN) nxt_core.cfg.mcycle = reg_wdata_in;
          A_BURST:  if (reg_wdata_in <= BURST_INF) nxt_core.cfg.burst = reg_wdata_in;
          A_DECTO:  if (in_rng(reg_wdata_in, DECTO_MIN, DECTO_MAX)) nxt_core.cfg.dec_to = reg_wdata_in;
          A_DUP:    if (reg_wdata_in <= DUP_MAX) nxt_core.cfg.dup = reg_wdata_in;
          A_GAIN:   nxt_core.cfg.gain = reg_wdata_in[7:0];
          A_HYST: begin
            nxt_core.cfg.hk     = reg_wdata_in[3:0];
            nxt_core.cfg.hwidth = reg_wdata_in[15:8];
          end
          A_FRMN:   if (in_rng(reg_wdata_in, FRMN_MIN, FRMN_MAX)) nxt_core.cfg.frame_n = reg_wdata_in[3:0];
          A_FGAP:   if (in_rng(reg_wdata_in, FGAP_MIN, FGAP_MAX)) nxt_core.cfg.gap = reg_wdata_in;
          A_MISS:   nxt_core.missed = 16'h0000;
          default:  ;
        endcase
      end
      // Applied after the clear so a same-cycle miss still counts
      if (bbusy && edge_det) nxt_core.missed = sat_inc(nxt_core.missed);

      if (reg_rd_in) begin
        case (reg_addr_in)
          A_CTRL:   nxt_core.rdata = {9'h000, core_ff.cfg.stop_good, core_ff.cfg.sup_bad,
                                      core_ff.cfg.async_en, core_ff.cfg.level_en,
                                      core_ff.cfg.falling, core_ff.cfg.mode};
          A_MCYCLE: nxt_core.rdata = core_ff.cfg.mcycle;
          A_BURST:  nxt_core.rdata = core_ff.cfg.burst;
          A_DECTO:  nxt_core.rdata = core_ff.cfg.dec_to;
          A_DUP:    nxt_core.rdata = core_ff.cfg.dup;
          A_GAIN:   nxt_core.rdata = {8'h00, core_ff.cfg.gain};
          A_HYST:   nxt_core.rdata = {core_ff.cfg.hwidth, 4'h0, core_ff.cfg.hk};
          A_FRMN:   nxt_core.rdata = {12'h000, core_ff.cfg.frame_n};
          A_FGAP:   nxt_core.rdata = core_ff.cfg.gap;
          A_MISS:   nxt_core.rdata = core_ff.missed;
          A_STAT:   nxt_core.rdata = {11'h000, core_ff.pend, act, core_ff.state};
          default:  nxt_core.rdata = 16'h0000;
        endcase
      end

      case (core_ff.state)
        ST_IDLE: begin
          if ((lvl_mode ? act : edge_det) && spaced) begin
            nxt_core.ms_trig  = 16'h0000;
            nxt_core.ms_burst = 16'h0000;
            nxt_core.budget   = 16'h0000;
            nxt_core.idx      = 5'h00;
            nxt_core.nimg     = 4'h0;
            nxt_core.state    = ST_PREP;
          end
        end
        ST_PREP: begin
          // Gain settles here, capture fires with it next cycle
          nxt_core.cap_pulse = 1'b1;
          nxt_core.budget    = (core_ff.budget > 16'hFFFF - ATTEMPT_MS - core_ff.cfg.dec_to)
                             ? 16'hFFFF : core_ff.budget + ATTEMPT_MS + core_ff.cfg.dec_to;
          nxt_core.state     = ST_CAP;
        end
        ST_CAP: begin
          if (cap_done_in) begin
            nxt_core.ms_dec = 16'h0000;
            nxt_core.state  = ST_DEC;
          end
        end
        ST_DEC: begin
          if (cap_done_in && core_ff.pend) nxt_core.caprdy = 1'b1;
          if (async_go) begin
            nxt_core.cap_pulse = 1'b1;
            nxt_core.pend      = 1'b1;
            nxt_core.ms_trig   = 16'h0000;
          end
          if (to_hit) nxt_core.abort_pulse = 1'b1;
          if (good) begin
            nxt_core.last_data = dec_in.data;
            nxt_core.have_last = 1'b1;
            nxt_core.ms_dup    = 16'h0000;
            if (!dup) begin
              nxt_core.res = '{valid: 1'b1, good: 1'b1, data: dec_in.data};
            end
          end else if (fin && !core_ff.cfg.sup_bad) begin
            nxt_core.res = '{valid: 1'b1, good: 1'b0, data: 16'h0000};
          end
          if (fin) begin
            case (core_ff.cfg.mode)
              MODE_SINGLE: begin
                if (core_ff.pend) begin
                  nxt_core.pend   = 1'b0;
                  nxt_core.caprdy = 1'b0;
                  nxt_core.ms_dec = 16'h0000;
                  nxt_core.state  = (core_ff.caprdy || cap_done_in) ? ST_DEC : ST_CAP;
                end else if (hyst_on && !good && !last_h) begin
                  nxt_core.idx   = nxt_step;
                  nxt_core.state = ST_PREP;
                end else if (lvl_mode && act) begin
                  nxt_core.idx   = 5'h00;
                  nxt_core.state = ST_PREP;
                end else begin
                  nxt_core.state = ST_IDLE;
                end
              end
              MODE_INTERVAL: begin
                if ((!unlim && core_ff.ms_burst >= core_ff.cfg.burst && core_ff.budget >= core_ff.cfg.burst)
                    || (core_ff.cfg.stop_good && !unlim && good)) begin
                  nxt_core.state = ST_IDLE;
                end else begin
                  nxt_core.idx   = good ? 5'h00 : nxt_step;
                  nxt_core.state = ST_PREP;
                end
              end
              MODE_FRAME: begin
                if (good || core_ff.nimg + 4'h1 >= core_ff.cfg.frame_n) begin
                  nxt_core.state = ST_IDLE;
                end else begin
                  nxt_core.nimg   = core_ff.nimg + 4'h1;
                  nxt_core.idx    = nxt_step;
                  nxt_core.ms_gap = 16'h0000;
                  nxt_core.state  = ST_GAP;
                end
              end
              default: nxt_core.state = ST_IDLE;
            endcase
          end
        end
        ST_GAP: begin
          if (core_ff.ms_gap >= core_ff.cfg.gap) nxt_core.state = ST_PREP;
        end
        default: nxt_core.state = ST_IDLE;
      endcase

      if (stop_req) begin
        if (core_ff.state == ST_DEC) nxt_core.abort_pulse = 1'b1;
        nxt_core.cap_pulse = 1'b0;
        nxt_core.state = ST_IDLE;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_ff         <= '0;
      core_ff.cfg     <= CFG_RST;
      core_ff.ms_trig <= 16'hFFFF;
    end else begin
      core_ff <= nxt_core;
    end
  end

  rts_gain_step u_gain (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .base_in    (core_ff.cfg.gain),
    .width_in   (core_ff.cfg.hwidth),
    .idx_in     (core_ff.idx),
    .gain_out   (gain_out)
  );

  assign reg_rdata_out = core_ff.rdata;
  assign capture_out   = core_ff.cap_pulse;
  assign abort_out     = core_ff.abort_pulse;
  assign res_out       = core_ff.res;
  assign busy_out      = core_ff.state != ST_IDLE;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  property p_edge_start;
    (core_ff.state == ST_IDLE && clk_en_in && !lvl_mode && edge_det && spaced) |=> (core_ff.state == ST_PREP);
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge did not start a cycle");

  property p_level_rep;
    (fin && clk_en_in && lvl_mode && act && !core_ff.pend && !hyst_on && !stop_req)
      |=> (core_ff.state == ST_PREP) ##1 (!clk_en_in || core_ff.cap_pulse);
  endproperty
  a_level_rep: assert property (p_level_rep) else $error("level mode did not repeat");

  property p_lvl_single;
    (core_ff.state == ST_IDLE && clk_en_in && core_ff.cfg.mode != MODE_SINGLE && !edge_det)
      |=> (core_ff.state == ST_IDLE);
  endproperty
  a_lvl_single: assert property (p_lvl_single) else $error("level start outside single mode");

  property p_no_async;
    (core_ff.state == ST_DEC && core_ff.cfg.mode == MODE_SINGLE && !core_ff.cfg.async_en) |-> !capture_out;
  endproperty
  a_no_async: assert property (p_no_async) else $error("capture during decode without async");

  property p_async;
    (async_go && clk_en_in && !stop_req) |=> (capture_out && core_ff.pend);
  endproperty
  a_async: assert property (p_async) else $error("async trigger not accepted");

  property p_sup;
    (fin && !good && clk_en_in && core_ff.cfg.sup_bad) |=> !res_out.valid;
  endproperty
  a_sup: assert property (p_sup) else $error("bad read not suppressed");

  property p_mcyc;
    (clk_en_in && reg_wr_in && reg_addr_in == A_MCYCLE && reg_wdata_in <= MCYCLE_MIN)
      |=> (core_ff.cfg.mcycle == $past(core_ff.cfg.mcycle));
  endproperty
  a_mcyc: assert property (p_mcyc) else $error("short machine cycle accepted");

  property p_missed;
    (clk_en_in && bbusy && edge_det && core_ff.missed != 16'hFFFF && !(reg_wr_in && reg_addr_in == A_MISS))
      |=> (core_ff.missed == $past(core_ff.missed) + 16'h0001);
  endproperty
  a_missed: assert property (p_missed) else $error("missed trigger not counted");

  property p_unlim_stop;
    (clk_en_in && stop_req) |=> (core_ff.state == ST_IDLE) && !capture_out;
  endproperty
  a_unlim_stop: assert property (p_unlim_stop) else $error("unlimited burst not stopped");

  sequence s_timeout;
    clk_en_in && to_hit && !stop_req;
  endsequence

  property p_abort;
    s_timeout |=> abort_out ##1 (!clk_en_in || !abort_out);
  endproperty
  a_abort: assert property (p_abort) else $error("decoder timeout did not abort");

  property p_gain_first;
    (capture_out && core_ff.idx == 5'h00 && $stable(core_ff.cfg.gain)) |-> (gain_out == core_ff.cfg.gain);
  endproperty
  a_gain_first: assert property (p_gain_first) else $error("first capture not at preset gain");

  property p_frame_max;
    (fin && clk_en_in && core_ff.cfg.mode == MODE_FRAME && core_ff.nimg + 4'h1 >= core_ff.cfg.frame_n)
      |=> (core_ff.state == ST_IDLE);
  endproperty
  a_frame_max: assert property (p_frame_max) else $error("frame burst exceeded image count");
endmodule
`default_nettype wire

// ==== verification/rts_imager_model.sv ====
// Imager and decoder stand-in answering capture pulses
`timescale 1ns/1ns
`default_nettype none
module rts_imager_model
  import rts_pkg::*;
(
  // Clock and request
  input  wire logic        clock_in,
  input  wire logic        capture_in,
  // Outcome to report
  input  wire logic        good_in,
  input  wire logic [15:0] data_in,
  input  wire logic        stall_in,
  // Answers
  output logic             cap_done_out,
  output rts_dec_t         dec_out
);
  int cnt = 0;
  // Data outside done toggles so no stale value passes
  always @(posedge clock_in) begin
    cap_done_out <= (cnt == 3);
    // Stall holds back done so the decoder limit must cut in
    dec_out      <= '{done: cnt == 8 && !stall_in, good: cnt == 8 && !stall_in && good_in,
                      data: cnt == 8 ? data_in : ~dec_out.data};
    cnt          <= capture_in ? 1 : (cnt != 0 && cnt < 9) ? cnt + 1 : 0;
  end
endmodule
`default_nettype wire

// ==== verification/test_rts_trigger_seq.sv ====
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module test_rts_trigger_seq
  import rts_pkg::*;
;
  logic        clock_in = 0, reset_n_in = 0, trig_in = 0, trig2_in = 0, good = 1, stall = 0;
  logic        reg_wr_in = 0, reg_rd_in = 0, cap_done_in, capture_out, abort_out, busy_out;
  logic [3:0]  reg_addr_in = 0;
  logic [15:0] reg_wdata_in = 0, reg_rdata_out, pdata = 0;
  logic [7:0]  gain_out;
  logic [31:0] seed = 32'h6A7CE7EE;
  rts_dec_t    dec_in;
  rts_res_t    res_out;
  int          fail_count = 0, n_checks = 0, caps = 0, aborts = 0, bcyc = 0;
  logic [16:0] exp_q[$], ev;
  logic [7:0]  gq[$];
  always #10 clock_in = ~clock_in;
  rts_trigger_seq #(.TICK_CYCLES(4)) rts_trigger_seq_i (.clock_in, .reset_n_in, .clk_en_in(1'b1), .trig_in,
    .trig2_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cap_done_in, .dec_in,
    .capture_out, .abort_out, .gain_out, .res_out, .busy_out);
  rts_imager_model rts_imager_model_i (.clock_in, .capture_in(capture_out), .good_in(good), .data_in(pdata),
    .stall_in(stall), .cap_done_out(cap_done_in), .dec_out(dec_in));
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    @(negedge clock_in);
    chk("rdata", reg_rdata_out, exp);
  endtask
  // Low gap of two cycles so the synchroniser sees every edge
  task automatic pulse();
    repeat (2) @(posedge clock_in);
    trig_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    trig_in <= 1'b0;
  endtask
  // Extra wait keeps the next trigger beyond the machine cycle
  task automatic settle();
    for (int i = 0; i < 4000 && busy_out !== 1'b0; i++) @(posedge clock_in);
    repeat (100) @(posedge clock_in);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (capture_out === 1'b1) begin
      caps++;
      if (gq.size() != 0) chk("gain", {8'h00, gain_out}, {8'h00, gq.pop_front()});
    end
    if (res_out.valid === 1'b1) begin
      ev = exp_q.size() != 0 ? exp_q.pop_front() : ~{res_out.good, res_out.data};
      chk("result", res_out.data, ev[15:0]);
      chk("result kind", {15'h0000, res_out.good}, {15'h0000, ev[16]});
    end
    if (abort_out === 1'b1) aborts++;
    if (busy_out === 1'b1) bcyc++;
  end
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rd(A_MCYCLE, RST_MCYCLE);
    rd(4'hF, 16'h0000);
    wr(A_MCYCLE, MCYCLE_MIN);
    rd(A_MCYCLE, RST_MCYCLE);
    wr(A_MCYCLE, 16'h0015);
    rd(A_MCYCLE, 16'h0015);
    wr(A_DUP, DUP_MAX);
    seed = xs(seed);
    pdata <= seed[15:0];
    exp_q.push_back({1'b1, seed[15:0]});
    repeat (2) begin
      pulse();
      settle();
    end
    chk("captures", caps[15:0], 16'h0002);
    wr(A_CTRL, 16'h0020);
    wr(A_GAIN, 16'h00FA);
    wr(A_HYST, 16'h0502);
    good <= 1'b0;
    caps = 0;
    gq = '{8'hFA, 8'hFF, 8'hF5, 8'hFF, 8'hF0};
    pulse();
    settle();
    chk("hyst captures", caps[15:0], 16'h0005);
    wr(A_CTRL, 16'h0021);
    wr(A_BURST, 16'h0064);
    wr(A_DECTO, DECTO_MIN);
    caps = 0;
    pulse();
    pulse();
    settle();
    rd(A_MISS, 16'h0001);
    chk("attempts", {15'h0000, caps >= 4}, 16'h0001);
    // Level enabled in interval mode must not restart after a stop
    wr(A_CTRL, 16'h0029);
    wr(A_BURST, BURST_INF);
    trig_in <= 1'b1;
    repeat (500) @(negedge clock_in);
    chk("unlimited", {15'h0000, busy_out}, 16'h0001);
    wr(A_CMD, CMD_STOP);
    repeat (20) @(posedge clock_in);
    trig_in <= 1'b0;
    @(negedge clock_in);
    chk("stop command", {15'h0000, busy_out}, 16'h0000);
    pulse();
    repeat (50) @(negedge clock_in);
    chk("burst running", {15'h0000, busy_out}, 16'h0001);
    @(posedge clock_in);
    trig2_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    trig2_in <= 1'b0;
    @(negedge clock_in);
    chk("second input stop", {15'h0000, busy_out}, 16'h0000);
    settle();
    wr(A_HYST, 16'h0000);
    wr(A_CTRL, 16'h0028);
    caps = 0;
    trig_in <= 1'b1;
    repeat (200) @(posedge clock_in);
    trig_in <= 1'b0;
    settle();
    chk("level repeats", {15'h0000, caps >= 10}, 16'h0001);
    wr(A_CTRL, 16'h0000);
    stall <= 1'b1;
    aborts = 0;
    exp_q.push_back(17'h00000);
    pulse();
    settle();
    chk("aborts", aborts[15:0], 16'h0001);
    stall <= 1'b0;
    wr(A_CTRL, 16'h0022);
    wr(A_FRMN, 16'h0003);
    wr(A_FGAP, FGAP_MIN);
    caps = 0;
    bcyc = 0;
    pulse();
    settle();
    chk("frame captures", caps[15:0], 16'h0003);
    chk("frame spacing", {15'h0000, bcyc >= 2 * 4 * FGAP_MIN}, 16'h0001);
    good <= 1'b1;
    wr(A_BURST, 16'h0064);
    for (int m = 0; m < 2; m++) begin
      seed = xs(seed);
      pdata <= seed[15:0];
      exp_q.push_back({1'b1, seed[15:0]});
      wr(A_CTRL, m == 0 ? 16'h0061 : 16'h0022);
      caps = 0;
      pulse();
      settle();
      chk("good read ends burst", caps[15:0], 16'h0001);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
